// [verilog/pms_pkg.sv]
package pms_pkg;

    // Register offsets
    localparam logic [7:0] OFF_CTRL     = 8'hD2;
    localparam logic [7:0] OFF_NRM_IVL  = 8'hD3;
    localparam logic [7:0] OFF_LOW_IVL  = 8'hD4;
    localparam logic [7:0] OFF_DEEP_IVL = 8'hD5;
    localparam logic [7:0] OFF_AUTO_TMR = 8'hD6;
    localparam logic [7:0] OFF_EV_MASK  = 8'hD7;
    localparam logic [7:0] OFF_IRQ_STAT = 8'hE0;
    localparam logic [7:0] OFF_IRQ_EN   = 8'hE1;
    localparam logic [7:0] OFF_IRQ_CLR  = 8'hE2;
    localparam logic [7:0] OFF_MODE     = 8'hE3;

    // Values after reset
    localparam logic [7:0] RST_CTRL     = 8'h03;
    localparam logic [7:0] RST_NRM_IVL  = 8'h10;
    localparam logic [7:0] RST_LOW_IVL  = 8'h30;
    localparam logic [7:0] RST_DEEP_IVL = 8'h08;
    localparam logic [7:0] RST_AUTO_TMR = 8'h14;
    localparam logic [7:0] RST_EV_MASK  = 8'h00;
    localparam logic [7:0] RST_IRQ_EN   = 8'h00;

    // Control field positions
    localparam int CTRL_PULSE_SEL   = 7;
    localparam int CTRL_ALLOW_DEEP  = 6;
    localparam int CTRL_AUTO_DIS    = 5;
    localparam int CTRL_MANUAL_HI   = 4;
    localparam int CTRL_MANUAL_LO   = 3;
    localparam int CTRL_SEG_HI      = 2;
    localparam int CTRL_SEG_LO      = 0;

    // Event mask bit positions
    localparam int EV_ABSORB_STATE  = 7;
    localparam int EV_POWER_UNIT    = 6;
    localparam int EV_SYSTEM        = 5;
    localparam int EV_TEMPERATURE   = 4;
    localparam int EV_HYSTERESIS    = 3;
    localparam int EV_MAGNETIC      = 2;
    localparam int EV_ABSORPTION    = 1;
    localparam int EV_PROXIMITY     = 0;

    // Timing
    localparam int CLK_PERIOD_NS    = 40;
    localparam int MS_TIME_NS       = 1000000;
    localparam int MS_CYCLES_DEF    = MS_TIME_NS / CLK_PERIOD_NS;
    localparam int DEEP_UNIT_MS     = 16;
    localparam int AUTO_UNIT_MS     = 500;
    localparam int SHORT_IVL_MS     = 4;

    typedef enum logic [1:0] {
        PMS_NORMAL,
        PMS_LOW,
        PMS_ULTRA,
        PMS_HALT
    } pms_mode_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pms_bus_s;

endpackage

// [verilog/pms_sync.sv]
`timescale 1ns/1ps
module pms_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    import pms_pkg::*;

    logic [WIDTH-1:0] meta_r;

    initial begin
        if (WIDTH < 1) $error("pms_sync: WIDTH must be at least 1");
    end

    // First stage is read only by the second
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end

endmodule

// [verilog/pms_tick.sv]
`timescale 1ns/1ps
module pms_tick #(
    parameter int CYCLES = pms_pkg::MS_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // One-cycle pulse per period
    output logic      tick
);
    import pms_pkg::*;

    logic [31:0] cnt_r;

    initial begin
        if (CYCLES < 2) $error("pms_tick: CYCLES must be at least 2");
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 32'h0000_0000;
            tick  <= 1'b0;
        end else if (cnt_r == 32'(CYCLES - 1)) begin
            cnt_r <= 32'h0000_0000;
            tick  <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'h0000_0001;
            tick  <= 1'b0;
        end
    end

endmodule

// [verilog/pms_top.sv]
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module pms_top #(
    parameter int MS_CYCLES    = pms_pkg::MS_CYCLES_DEF,
    parameter bit BASE_VARIANT = 1'b1
) (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    // Register port
    input  wire pms_pkg::pms_bus_s  bus,
    output logic [7:0]              reg_rdata,
    // Activity pin, event sources, pulse source
    input  wire logic               activity_pin,
    input  wire logic [7:0]         event_src,
    input  wire logic               pulse_level,
    // Scheduling
    output pms_pkg::pms_mode_e      power_mode,
    output logic                    report_tick,
    output logic                    segment_tick,
    output logic                    wake_channel_only,
    output logic                    all_channels_run,
    // Shared pin and transmit enable
    output logic                    inductive_transmit_en,
    output logic                    shared_output_pin_o,
    output logic                    shared_output_pin_oe,
    // Events and interrupt
    output logic [7:0]              event_out,
    output logic                    irq
);
    import pms_pkg::*;

    typedef struct packed {
        pms_mode_e   mode;
        logic [7:0]  ctrl;
        logic [7:0]  nrm_ivl;
        logic [7:0]  low_ivl;
        logic [7:0]  deep_ivl;
        logic [7:0]  auto_tmr;
        logic [7:0]  ev_mask;
        logic [7:0]  irq_stat;
        logic [7:0]  irq_en;
        logic [7:0]  rdata;
        logic [11:0] ivl_cnt;
        logic [16:0] idle_cnt;
        logic [8:0]  seg_cnt;
        logic        report;
        logic        seg_tick;
        logic        wake_only;
        logic        all_run;
        logic        xmit_en;
        logic        pin_o;
        logic        pin_oe;
        logic [7:0]  ev_out;
        logic        irq;
    } pms_state_s;

    initial begin
        if (MS_CYCLES < 2) $error("pms_top: MS_CYCLES must be at least 2");
    end

    // Reset release synchroniser
    logic [1:0] rst_sync_r;
    logic       rst_core_n;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_core_n = rst_sync_r[1];

    logic act_q;
    logic ms_tick;

    pms_sync #(.WIDTH(1)) u_act_sync (
        .core_clk (core_clk),
        .rst_n    (rst_core_n),
        .din      (activity_pin),
        .dout     (act_q)
    );

    pms_tick #(.CYCLES(MS_CYCLES)) u_ms_tick (
        .core_clk (core_clk),
        .rst_n    (rst_core_n),
        .tick     (ms_tick)
    );

    function automatic pms_mode_e decode_mode(input logic [1:0] code);
        case (code)
            2'b00:   decode_mode = PMS_NORMAL;
            2'b01:   decode_mode = PMS_LOW;
            2'b10:   decode_mode = PMS_ULTRA;
            default: decode_mode = PMS_HALT;
        endcase
    endfunction

    // Report interval in ms for a mode
    function automatic logic [11:0] mode_interval(input pms_mode_e m, input pms_state_s s);
        case (m)
            PMS_NORMAL: mode_interval = {4'h0, s.nrm_ivl};
            PMS_LOW:    mode_interval = {4'h0, s.low_ivl};
            PMS_ULTRA:  mode_interval = 12'(s.deep_ivl * DEEP_UNIT_MS);
            default:    mode_interval = 12'h000;
        endcase
    endfunction

    pms_state_s st_r;
    pms_state_s nxt;
    pms_mode_e  manual_mode;
    pms_mode_e  mode_new;
    logic [11:0] ivl_tgt;
    logic [16:0] auto_tgt;
    logic [8:0]  seg_lim;
    logic [7:0]  ev_raw;
    logic [7:0]  ev_pass;
    logic [7:0]  clr_bits;
    logic        pulse_on;
    logic        allow_deep;

    assign manual_mode = decode_mode(st_r.ctrl[CTRL_MANUAL_HI:CTRL_MANUAL_LO]);
    assign pulse_on    = st_r.ctrl[CTRL_PULSE_SEL];
    assign allow_deep  = st_r.ctrl[CTRL_ALLOW_DEEP];

    always_comb begin
        nxt      = st_r;
        mode_new = st_r.mode;
        ivl_tgt  = 12'h000;
        auto_tgt = 17'(st_r.auto_tmr * AUTO_UNIT_MS);
        seg_lim  = 9'(9'h002 << st_r.ctrl[CTRL_SEG_HI:CTRL_SEG_LO]);
        ev_raw   = 8'h00;
        ev_pass  = 8'h00;
        clr_bits = 8'h00;
        nxt.report   = 1'b0;
        nxt.seg_tick = 1'b0;
        nxt.rdata    = 8'h00;

        // Mode selection
        if (st_r.ctrl[CTRL_AUTO_DIS]) begin
            // Halt is left only by a host write to the control register
            mode_new     = manual_mode;
            nxt.idle_cnt = 17'h00000;
        end else if (act_q) begin
            mode_new     = PMS_NORMAL;
            nxt.idle_cnt = 17'h00000;
        end else if (ms_tick) begin
            if (st_r.idle_cnt + 17'h00001 >= auto_tgt) begin
                nxt.idle_cnt = 17'h00000;
                case (st_r.mode)
                    PMS_NORMAL: mode_new = PMS_LOW;
                    PMS_LOW:    mode_new = allow_deep ? PMS_ULTRA : PMS_LOW;
                    PMS_ULTRA:  mode_new = PMS_ULTRA;
                    default:    mode_new = PMS_NORMAL;
                endcase
            end else begin
                nxt.idle_cnt = st_r.idle_cnt + 17'h00001;
            end
        end
        // Withdrawn permission pulls auto mode back out of deepest sleep
        if (!st_r.ctrl[CTRL_AUTO_DIS] && !allow_deep && mode_new == PMS_ULTRA) begin
            mode_new = PMS_LOW;
        end
        if (BASE_VARIANT && pulse_on) begin
            mode_new = PMS_NORMAL;
        end
        nxt.mode = mode_new;

        // Report scheduling in whole ms ticks
        // Exact count here; short intervals may stretch in the converters
        ivl_tgt = mode_interval(st_r.mode, st_r);
        if (mode_new != st_r.mode) begin
            nxt.ivl_cnt = 12'h000;
            nxt.seg_cnt = 9'h000;
        end else if (ms_tick && st_r.mode != PMS_HALT) begin
            if (st_r.ivl_cnt + 12'h001 >= ivl_tgt) begin
                nxt.ivl_cnt = 12'h000;
                nxt.report  = 1'b1;
                if (st_r.mode == PMS_ULTRA) begin
                    if (st_r.seg_cnt + 9'h001 >= seg_lim) begin
                        nxt.seg_cnt  = 9'h000;
                        nxt.seg_tick = 1'b1;
                    end else begin
                        nxt.seg_cnt = st_r.seg_cnt + 9'h001;
                    end
                end
            end else begin
                nxt.ivl_cnt = st_r.ivl_cnt + 12'h001;
            end
        end
        nxt.wake_only = (mode_new == PMS_ULTRA);
        nxt.all_run   = (mode_new == PMS_NORMAL) || (mode_new == PMS_LOW);

        // Shared pin
        nxt.pin_oe = pulse_on;
        nxt.pin_o  = pulse_on & pulse_level;
        nxt.xmit_en = ~pulse_on;

        // Events; a mode change is a power-unit event
        ev_raw = event_src;
        ev_raw[EV_POWER_UNIT] = event_src[EV_POWER_UNIT] | (mode_new != st_r.mode);
        ev_pass = ev_raw & ~st_r.ev_mask;
        nxt.ev_out = ev_pass;

        // Register writes
        if (bus.wr) begin
            case (bus.addr)
                OFF_CTRL:     nxt.ctrl     = bus.wdata;
                OFF_NRM_IVL:  nxt.nrm_ivl  = bus.wdata;
                OFF_LOW_IVL:  nxt.low_ivl  = bus.wdata;
                OFF_DEEP_IVL: nxt.deep_ivl = bus.wdata;
                OFF_AUTO_TMR: nxt.auto_tmr = bus.wdata;
                OFF_EV_MASK:  nxt.ev_mask  = bus.wdata;
                OFF_IRQ_EN:   nxt.irq_en   = bus.wdata;
                OFF_IRQ_CLR:  clr_bits     = bus.wdata;
                default:      nxt.ctrl     = st_r.ctrl;
            endcase
        end
        // New events win over a clear in the same cycle
        nxt.irq_stat = (st_r.irq_stat & ~clr_bits) | ev_pass;
        nxt.irq      = |(nxt.irq_stat & nxt.irq_en);

        // Register reads, data valid the following cycle
        if (bus.rd) begin
            case (bus.addr)
                OFF_CTRL:     nxt.rdata = st_r.ctrl;
                OFF_NRM_IVL:  nxt.rdata = st_r.nrm_ivl;
                OFF_LOW_IVL:  nxt.rdata = st_r.low_ivl;
                OFF_DEEP_IVL: nxt.rdata = st_r.deep_ivl;
                OFF_AUTO_TMR: nxt.rdata = st_r.auto_tmr;
                OFF_EV_MASK:  nxt.rdata = st_r.ev_mask;
                OFF_IRQ_STAT: nxt.rdata = st_r.irq_stat;
                OFF_IRQ_EN:   nxt.rdata = st_r.irq_en;
                OFF_MODE:     nxt.rdata = {6'h00, st_r.mode};
                default:      nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            st_r          <= '0;
            st_r.mode     <= PMS_NORMAL;
            st_r.ctrl     <= RST_CTRL;
            st_r.nrm_ivl  <= RST_NRM_IVL;
            st_r.low_ivl  <= RST_LOW_IVL;
            st_r.deep_ivl <= RST_DEEP_IVL;
            st_r.auto_tmr <= RST_AUTO_TMR;
            st_r.ev_mask  <= RST_EV_MASK;
            st_r.irq_en   <= RST_IRQ_EN;
            st_r.all_run  <= 1'b1;
            st_r.xmit_en  <= 1'b1;
        end else begin
            st_r <= nxt;
        end
    end

    assign power_mode            = st_r.mode;
    assign reg_rdata             = st_r.rdata;
    assign report_tick           = st_r.report;
    assign segment_tick          = st_r.seg_tick;
    assign wake_channel_only     = st_r.wake_only;
    assign all_channels_run      = st_r.all_run;
    assign inductive_transmit_en = st_r.xmit_en;
    assign shared_output_pin_o   = st_r.pin_o;
    assign shared_output_pin_oe  = st_r.pin_oe;
    assign event_out             = st_r.ev_out;
    assign irq                   = st_r.irq;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_core_n);

    pin_xmit_a: assert property (
        pulse_on |=> shared_output_pin_oe && !inductive_transmit_en)
        else $error("pulse select did not take the pin from transmit");

    pulse_normal_a: assert property (
        BASE_VARIANT && pulse_on |=> power_mode == PMS_NORMAL)
        else $error("left normal mode while pulse output active");

    no_ultra_a: assert property (
        !allow_deep && !st_r.ctrl[CTRL_AUTO_DIS] |=> power_mode != PMS_ULTRA)
        else $error("auto switching entered deepest sleep while barred");

    manual_fix_a: assert property (
        st_r.ctrl[CTRL_AUTO_DIS] && !(BASE_VARIANT && pulse_on) |=> power_mode == $past(manual_mode))
        else $error("fixed mode does not follow manual field");

    halt_quiet_a: assert property (
        report_tick |-> power_mode != PMS_HALT && power_mode == $past(power_mode))
        else $error("report issued in halt or across a mode change");

    seg_ultra_a: assert property (
        segment_tick |-> report_tick && wake_channel_only && power_mode == PMS_ULTRA)
        else $error("segment tick outside deepest-sleep report");

    mask_block_a: assert property (
        1'b1 |=> (event_out & $past(st_r.ev_mask)) == 8'h00)
        else $error("masked event source passed");

    // Without a control write a fixed halt must persist
    halt_hold_a: assert property (
        st_r.ctrl[CTRL_AUTO_DIS] && power_mode == PMS_HALT && !($past(bus.wr) && $past(bus.addr) == OFF_CTRL)
        && !(bus.wr && bus.addr == OFF_CTRL) |=> power_mode == PMS_HALT)
        else $error("halt left without a host write");

    step_down_a: assert property (
        power_mode == PMS_NORMAL && !st_r.ctrl[CTRL_AUTO_DIS] |=> power_mode != PMS_ULTRA)
        else $error("auto switching skipped low power mode");

    rdata_idle_a: assert property (
        !bus.rd |=> reg_rdata == 8'h00)
        else $error("read data outside the read answer cycle");

    sequence clr_hit_s;
        bus.wr && bus.addr == OFF_IRQ_CLR && |(event_src & ~st_r.ev_mask & bus.wdata);
    endsequence
    sequence stat_kept_s;
        ##1 |(st_r.irq_stat & $past(event_src & ~st_r.ev_mask));
    endsequence
    set_wins_a: assert property (clr_hit_s |-> stat_kept_s)
        else $error("event lost to simultaneous clear");

    sequence auto_act_s;
        act_q && !st_r.ctrl[CTRL_AUTO_DIS];
    endsequence
    act_wake_a: assert property (auto_act_s |=> power_mode == PMS_NORMAL)
        else $error("activity did not return to normal mode");

endmodule

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb;
    import pms_pkg::*;
    localparam int MSC = 10;
    logic       core_clk;
    logic       rst_n;
    logic       activity_pin;
    logic       pulse_level;
    pms_bus_s   bus;
    logic [7:0] event_src;
    logic [7:0] reg_rdata;
    logic [7:0] event_out;
    pms_mode_e  power_mode;
    logic       report_tick;
    logic       segment_tick;
    logic       wake_channel_only;
    logic       all_channels_run;
    logic       inductive_transmit_en;
    logic       shared_output_pin_o;
    logic       shared_output_pin_oe;
    logic       irq;
    int         err_total;
    int         samples_checked;
    int         cyc;

    pms_top #(.MS_CYCLES(MSC)) i_pms_top (
        .core_clk(core_clk), .rst_n(rst_n), .bus(bus), .reg_rdata(reg_rdata),
        .activity_pin(activity_pin), .event_src(event_src), .pulse_level(pulse_level),
        .power_mode(power_mode), .report_tick(report_tick), .segment_tick(segment_tick),
        .wake_channel_only(wake_channel_only), .all_channels_run(all_channels_run),
        .inductive_transmit_en(inductive_transmit_en), .shared_output_pin_o(shared_output_pin_o),
        .shared_output_pin_oe(shared_output_pin_oe), .event_out(event_out), .irq(irq)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    always @(posedge core_clk) cyc <= cyc + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask

    // Read data is only valid in the single cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d, e);
    endtask

    task automatic wait_rep(output int c);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            #1 n++;
        end while (report_tick !== 1'b1 && n < 3000);
        chk(report_tick, 1'b1);
        c = cyc;
    endtask

    task automatic pulse_ev(input logic [7:0] v);
        @(posedge core_clk);
        event_src <= v;
        @(posedge core_clk);
        event_src <= 8'h00;
        @(posedge core_clk);
        #1;
    endtask

    task automatic t_regs();
        logic [7:0] offs [6] = '{OFF_CTRL, OFF_NRM_IVL, OFF_LOW_IVL, OFF_DEEP_IVL, OFF_AUTO_TMR, OFF_EV_MASK};
        logic [7:0] vals [6] = '{RST_CTRL, RST_NRM_IVL, RST_LOW_IVL, RST_DEEP_IVL, RST_AUTO_TMR, RST_EV_MASK};
        foreach (offs[i]) rdchk(offs[i], vals[i]);
        rdchk(OFF_IRQ_EN, RST_IRQ_EN);
        wr(OFF_EV_MASK, 8'h5A);
        rdchk(OFF_EV_MASK, 8'h5A);
        wr(8'hD0, 8'hFF);
        rdchk(8'hD0, 8'h00);
        wr(OFF_IRQ_STAT, 8'hFF);
        rdchk(OFF_IRQ_STAT, 8'h00);
        rdchk(OFF_IRQ_CLR, 8'h00);
        wr(OFF_EV_MASK, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_rate(input logic [1:0] code, input logic [7:0] a, input logic [7:0] v, input int exp,
                          input pms_mode_e pm);
        int t1;
        int t2;
        wr(a, v);
        wr(OFF_CTRL, {3'b001, code, 3'b000});
        wait_rep(t1);
        wait_rep(t2);
        chk(t2 - t1, exp);
        chk(power_mode, pm);
        chk(all_channels_run, 1'b1);
    endtask

    task automatic t_manual();
        wr(OFF_CTRL, 8'h08);
        repeat (3) @(posedge core_clk);
        #1 chk(power_mode, PMS_NORMAL);
        t_rate(2'b00, OFF_NRM_IVL, 8'h02, 2 * MSC, PMS_NORMAL);
        t_rate(2'b00, OFF_NRM_IVL, 8'h00, MSC, PMS_NORMAL);
        t_rate(2'b01, OFF_LOW_IVL, 8'h03, 3 * MSC, PMS_LOW);
        $display("test manual done");
    endtask

    task automatic t_ultra();
        int t1;
        int t2;
        int seg;
        seg = 0;
        wr(OFF_DEEP_IVL, 8'h01);
        wr(OFF_CTRL, 8'h31);
        rdchk(OFF_MODE, 8'(PMS_ULTRA));
        wait_rep(t1);
        wait_rep(t2);
        chk(t2 - t1, DEEP_UNIT_MS * MSC);
        chk(power_mode, PMS_ULTRA);
        chk({wake_channel_only, all_channels_run}, 2'b10);
        // Eight reports hold exactly two multiples of four
        repeat (8) begin
            wait_rep(t1);
            seg += int'(segment_tick === 1'b1);
        end
        chk(seg, 2);
        $display("test ultra done");
    endtask

    task automatic t_halt();
        int n;
        n = 0;
        wr(OFF_CTRL, 8'h38);
        repeat (2) @(posedge core_clk);
        #1 chk(power_mode, PMS_HALT);
        repeat (100) begin
            @(posedge core_clk);
            #1 n += int'(report_tick === 1'b1);
        end
        chk(n, 0);
        wr(OFF_CTRL, 8'h20);
        repeat (2) @(posedge core_clk);
        #1 chk(power_mode, PMS_NORMAL);
        $display("test halt done");
    endtask

    task automatic t_pulse();
        wr(OFF_CTRL, 8'hB8);
        pulse_level <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1 chk({shared_output_pin_oe, shared_output_pin_o, inductive_transmit_en}, 3'b110);
        chk(power_mode, PMS_NORMAL);
        @(posedge core_clk);
        pulse_level <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 chk(shared_output_pin_o, 1'b0);
        wr(OFF_CTRL, 8'h20);
        repeat (2) @(posedge core_clk);
        #1 chk({shared_output_pin_oe, inductive_transmit_en}, 2'b01);
        $display("test pulse done");
    endtask

    task automatic t_auto();
        int t0;
        wr(OFF_AUTO_TMR, 8'h00);
        wr(OFF_CTRL, 8'h00);
        repeat (60) @(posedge core_clk);
        #1 chk(power_mode, PMS_LOW);
        wr(OFF_CTRL, 8'h40);
        repeat (30) @(posedge core_clk);
        #1 chk(power_mode, PMS_ULTRA);
        activity_pin <= 1'b1;
        repeat (40) @(posedge core_clk);
        #1 chk(power_mode, PMS_NORMAL);
        activity_pin <= 1'b0;
        wr(OFF_CTRL, 8'h20);
        repeat (60) @(posedge core_clk);
        #1 chk(power_mode, PMS_NORMAL);
        wr(OFF_AUTO_TMR, 8'h01);
        activity_pin <= 1'b1;
        wr(OFF_CTRL, 8'h00);
        @(posedge core_clk);
        activity_pin <= 1'b0;
        #1 t0 = cyc;
        // Sampled 1 ns after each edge so mode and count are settled
        while (power_mode === PMS_NORMAL && cyc - t0 < 6000) begin
            @(posedge core_clk);
            #1;
        end
        // Tick phase may cut up to one ms; sync delay adds a few cycles
        chk((cyc - t0 >= 499 * MSC) && (cyc - t0 <= 500 * MSC + 20), 1'b1);
        $display("test auto done");
    endtask

    task automatic t_events();
        wr(OFF_CTRL, 8'h20);
        for (int i = 0; i < 8; i++) begin
            wr(OFF_EV_MASK, 8'h01 << i);
            @(posedge core_clk);
            event_src <= 8'hFF;
            @(posedge core_clk);
            event_src <= 8'h00;
            #1 chk(event_out, 8'(~(8'h01 << i)));
        end
        wr(OFF_EV_MASK, 8'h00);
        wr(OFF_IRQ_CLR, 8'hFF);
        wr(OFF_IRQ_EN, 8'h08);
        rdchk(OFF_IRQ_STAT, 8'h00);
        pulse_ev(8'h01);
        chk(irq, 1'b0);
        pulse_ev(8'h08);
        chk(irq, 1'b1);
        rdchk(OFF_IRQ_STAT, 8'h09);
        wr(OFF_IRQ_EN, 8'h00);
        @(posedge core_clk);
        #1 chk(irq, 1'b0);
        wr(OFF_IRQ_EN, 8'h08);
        @(posedge core_clk);
        #1 chk(irq, 1'b1);
        wr(OFF_IRQ_CLR, 8'h08);
        @(posedge core_clk);
        #1 chk(irq, 1'b0);
        rdchk(OFF_IRQ_STAT, 8'h01);
        // Event and clear of one bit in the same cycle: the event stays
        @(posedge core_clk);
        bus <= '{addr: OFF_IRQ_CLR, wdata: 8'h08, wr: 1'b1, rd: 1'b0};
        event_src <= 8'h08;
        @(posedge core_clk);
        bus.wr <= 1'b0;
        event_src <= 8'h00;
        rdchk(OFF_IRQ_STAT, 8'h09);
        chk(irq, 1'b1);
        $display("test events done");
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge core_clk);
        err_total++;
        end_sim();
    end

    initial begin
        rst_n = 1'b0;
        bus = '0;
        activity_pin = 1'b0;
        pulse_level = 1'b0;
        event_src = 8'h00;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_regs();
        t_manual();
        t_ultra();
        t_halt();
        t_pulse();
        t_auto();
        t_events();
        end_sim();
    end
endmodule
